// ==== roi_defs.svh ====
// Constants for the windowed readout sequencer: offsets, fields, reset values and timing.
`ifndef ROI_DEFS_SVH
`define ROI_DEFS_SVH

// ==========================================================================
// Register offsets
`define ROI_REG_CTRL        8'h00
`define ROI_REG_ROW_START   8'h04
`define ROI_REG_COL_START   8'h08
`define ROI_REG_REF_LEVEL   8'h0C
`define ROI_REG_WIN_WIDTH   8'h10
`define ROI_REG_WIN_HEIGHT  8'h14
`define ROI_REG_STATUS      8'h18

// ==========================================================================
// Field positions and widths
`define ROI_CTRL_ENABLE     0
`define ROI_CTRL_DUAL       1
`define ROI_START_W         10
`define ROI_REF_W           7
`define ROI_ADDR_W          11
`define ROI_CNT_W           12
`define ROI_PIX_W           10
`define ROI_STAT_BUSY       0
`define ROI_STAT_STATE_LSB  4
`define ROI_STAT_ROW_LSB    16

// ==========================================================================
// Reset values
`define ROI_CTRL_RST        2'h0
`define ROI_START_RST       10'h000
`define ROI_REF_RST         7'h7F
`define ROI_ARRAY_RST       12'h800

// ==========================================================================
// Timing
`define ROI_CLK_PERIOD_NS   100
`define ROI_FOT_NS          5000
`define ROI_ROT_NS          200
`define ROI_FOT_CYC         ((`ROI_FOT_NS + `ROI_CLK_PERIOD_NS - 1) / `ROI_CLK_PERIOD_NS)
`define ROI_ROT_CYC         ((`ROI_ROT_NS + `ROI_CLK_PERIOD_NS - 1) / `ROI_CLK_PERIOD_NS)
`define ROI_FIFO_DEPTH      8

`endif

// ==== roi_pkg.sv ====
// Types shared by the windowed readout sequencer modules.
`default_nettype none
package roi_pkg;
	typedef enum logic [2:0] {
		ROI_IDLE = 3'h0,
		ROI_FOT  = 3'h1,
		ROI_ROT  = 3'h3,
		ROI_PIX  = 3'h2
	} roi_state_type;

	typedef enum logic [2:0] {
		ROI_SEL_CTRL,
		ROI_SEL_ROW,
		ROI_SEL_COL,
		ROI_SEL_REF,
		ROI_SEL_WIDTH,
		ROI_SEL_HEIGHT,
		ROI_SEL_STATUS,
		ROI_SEL_NONE
	} roi_sel_type;
endpackage : roi_pkg
`default_nettype wire

// ==== roi_stream_if.sv ====
// Valid/ready stream carrying pixel pairs between the sequencer modules.
`timescale 1ns/1ps
`default_nettype none
interface roi_stream_if #(parameter int WIDTH = 20);
	logic             valid;
	logic             ready;
	logic [WIDTH-1:0] data;
	modport source (output valid, output data, input ready);
	modport sink   (input valid, input data, output ready);
endinterface : roi_stream_if
`default_nettype wire

// ==== roi_fifo.sv ====
// Pixel pair FIFO with parameterised width and depth.
`timescale 1ns/1ps
`default_nettype none
module roi_fifo import roi_pkg::*; #(
	parameter int WIDTH = 20,
	parameter int DEPTH = 8
) (
	input  wire logic   aclk,
	input  wire logic   aresetn,
	input  wire logic   ce,
	roi_stream_if.sink   in_s,
	roi_stream_if.source out_s
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    rd_ptr;
	logic [AW-1:0]    next_rd_ptr;
	logic [AW-1:0]    wr_ptr;
	logic [AW-1:0]    next_wr_ptr;
	logic [AW:0]      count;
	logic [AW:0]      next_count;
	logic             push;
	logic             pop;

	assign in_s.ready  = ce && (count != (AW+1)'(DEPTH));
	assign out_s.valid = ce && (count != '0);
	assign out_s.data  = mem[rd_ptr];
	assign push        = in_s.valid && in_s.ready;
	assign pop         = out_s.valid && out_s.ready;

	always_comb begin
		next_wr_ptr = push ? AW'((wr_ptr + 1'b1) % DEPTH) : wr_ptr;
		next_rd_ptr = pop ? AW'((rd_ptr + 1'b1) % DEPTH) : rd_ptr;
		next_count  = count + (AW+1)'(push) - (AW+1)'(pop);
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rd_ptr <= '0;
			wr_ptr <= '0;
			count  <= '0;
		end else if (ce) begin
			rd_ptr <= next_rd_ptr;
			wr_ptr <= next_wr_ptr;
			count  <= next_count;
		end
	end

	always_ff @(posedge aclk) begin
		if (ce && push) begin
			mem[wr_ptr] <= in_s.data;
		end
	end
endmodule : roi_fifo
`default_nettype wire

// ==== roi_out_stage.sv ====
// Output stages: single path multiplexing both column buses, or two in-phase paths.
`timescale 1ns/1ps
`default_nettype none
`include "roi_defs.svh"
module roi_out_stage import roi_pkg::*; (
	input  wire logic                   aclk,
	input  wire logic                   aresetn,
	input  wire logic                   ce,
	input  wire logic                   dual,
	input  wire logic [`ROI_REF_W-1:0]  ref_code,
	roi_stream_if.sink                  pairs,
	output logic [`ROI_PIX_W-1:0]       pixel_signal_output_a,
	output logic [`ROI_PIX_W-1:0]       pixel_signal_output_b,
	output logic                        pixel_strobe,
	output logic [`ROI_REF_W-1:0]       reference_level_output_a,
	output logic [`ROI_REF_W-1:0]       reference_level_output_b
);
	logic                  phase;
	logic                  next_phase;
	logic [`ROI_PIX_W-1:0] next_a;
	logic [`ROI_PIX_W-1:0] next_b;
	logic                  next_strobe;

	// In single-output mode the odd half is sent on the second cycle, so a pair is popped only then.
	assign pairs.ready = ce && (dual || phase);

	always_comb begin
		next_phase  = phase;
		next_a      = pixel_signal_output_a;
		next_b      = pixel_signal_output_b;
		next_strobe = 1'b0;
		if (pairs.valid) begin
			next_strobe = 1'b1;
			if (dual) begin
				next_a     = pairs.data[`ROI_PIX_W-1:0];
				next_b     = pairs.data[2*`ROI_PIX_W-1:`ROI_PIX_W];
				next_phase = 1'b0;
			end else begin
				next_a     = phase ? pairs.data[2*`ROI_PIX_W-1:`ROI_PIX_W] : pairs.data[`ROI_PIX_W-1:0];
				next_b     = '0;
				next_phase = !phase;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			phase                    <= 1'b0;
			pixel_signal_output_a    <= '0;
			pixel_signal_output_b    <= '0;
			pixel_strobe             <= 1'b0;
			reference_level_output_a <= `ROI_REF_RST;
			reference_level_output_b <= `ROI_REF_RST;
		end else if (ce) begin
			phase                    <= next_phase;
			pixel_signal_output_a    <= next_a;
			pixel_signal_output_b    <= next_b;
			pixel_strobe             <= next_strobe;
			reference_level_output_a <= ref_code;
			reference_level_output_b <= ref_code;
		end
	end
endmodule : roi_out_stage
`default_nettype wire

// ==== roi_readout.sv ====
// Windowed readout addressing and output sequencing for a 2048 by 2048 array.
// ==========================================================================
// Overview of operation
// - The window set by the width and height registers, up to the whole 2048 by 2048 array, is read line after line in progressive order.
// - One column address register and two row address registers select the pixels being read.
// - Pixels leave on one path or on two parallel paths, each path carrying one sample per clock.
// - Row and column start positions step by two, so only even starts exist.
// - Row start and column start are each a 10-bit register loaded by the controller.
// - A loaded start n begins readout at line 2n and column 2n.
// - A column or row sync pulse presets the matching address register to its start value, and the second row register to one past it.
// - A frame is one frame overhead plus, per line, one row overhead and, in dual-output mode, one clock per pixel pair.
// - The frame overhead lasts 5 us once per frame before the first line.
// - The row overhead lasts 200 ns per line.
// - In single-output mode the two column buses are multiplexed alternately onto one output.
// - In dual-output mode both outputs carry their samples in phase.
// - Each output stage drives a reference level set by a 7-bit code.
`timescale 1ns/1ps
`default_nettype none
`include "roi_defs.svh"
module roi_readout import roi_pkg::*; (
	input  wire logic                    aclk,
	input  wire logic                    aresetn,
	input  wire logic                    ce,
	input  wire logic [7:0]              s_axi_awaddr,
	input  wire logic [2:0]              s_axi_awprot,
	input  wire logic                    s_axi_awvalid,
	output logic                         s_axi_awready,
	input  wire logic [31:0]             s_axi_wdata,
	input  wire logic [3:0]              s_axi_wstrb,
	input  wire logic                    s_axi_wvalid,
	output logic                         s_axi_wready,
	output logic [1:0]                   s_axi_bresp,
	output logic                         s_axi_bvalid,
	input  wire logic                    s_axi_bready,
	input  wire logic [7:0]              s_axi_araddr,
	input  wire logic [2:0]              s_axi_arprot,
	input  wire logic                    s_axi_arvalid,
	output logic                         s_axi_arready,
	output logic [31:0]                  s_axi_rdata,
	output logic [1:0]                   s_axi_rresp,
	output logic                         s_axi_rvalid,
	input  wire logic                    s_axi_rready,
	input  wire logic                    sync_x_pin,
	input  wire logic                    sync_y_pin,
	input  wire logic [`ROI_PIX_W-1:0]   col_bus_even,
	input  wire logic [`ROI_PIX_W-1:0]   col_bus_odd,
	output logic [`ROI_ADDR_W-1:0]       col_addr,
	output logic [`ROI_ADDR_W-1:0]       row_addr_sel,
	output logic [`ROI_ADDR_W-1:0]       row_addr_prep,
	output logic                         frame_busy,
	output logic [`ROI_PIX_W-1:0]        pixel_signal_output_a,
	output logic [`ROI_PIX_W-1:0]        pixel_signal_output_b,
	output logic                         pixel_strobe,
	output logic [`ROI_REF_W-1:0]        reference_level_output_a,
	output logic [`ROI_REF_W-1:0]        reference_level_output_b
);
	localparam logic [7:0] FOT_LAST = 8'(`ROI_FOT_CYC - 1);
	localparam logic [7:0] ROT_LAST = 8'(`ROI_ROT_CYC - 1);
	// ==========================================================================
	// Register decode and byte-lane merge
	function automatic roi_sel_type decode(input logic [7:0] addr);
		if (addr == `ROI_REG_CTRL) begin
			return ROI_SEL_CTRL;
		end else if (addr == `ROI_REG_ROW_START) begin
			return ROI_SEL_ROW;
		end else if (addr == `ROI_REG_COL_START) begin
			return ROI_SEL_COL;
		end else if (addr == `ROI_REG_REF_LEVEL) begin
			return ROI_SEL_REF;
		end else if (addr == `ROI_REG_WIN_WIDTH) begin
			return ROI_SEL_WIDTH;
		end else if (addr == `ROI_REG_WIN_HEIGHT) begin
			return ROI_SEL_HEIGHT;
		end else if (addr == `ROI_REG_STATUS) begin
			return ROI_SEL_STATUS;
		end else begin
			return ROI_SEL_NONE;
		end
	endfunction : decode
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] data, input logic [3:0] strb);
		logic [31:0] res;
		res = old;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				res[8*i +: 8] = data[8*i +: 8];
			end
		end
		return res;
	endfunction : merge
	// ==========================================================================
	// Registers and their next values
	logic [1:0]                 ctrl;
	logic [`ROI_START_W-1:0]    row_start;
	logic [`ROI_START_W-1:0]    col_start;
	logic [`ROI_REF_W-1:0]      ref_code;
	logic [`ROI_CNT_W-1:0]      win_width;
	logic [`ROI_CNT_W-1:0]      win_height;
	logic [1:0]                 next_ctrl;
	logic [`ROI_START_W-1:0]    next_row_start;
	logic [`ROI_START_W-1:0]    next_col_start;
	logic [`ROI_REF_W-1:0]      next_ref_code;
	logic [`ROI_CNT_W-1:0]      next_win_width;
	logic [`ROI_CNT_W-1:0]      next_win_height;
	logic                       aw_held;
	logic                       w_held;
	logic [7:0]                 aw_addr;
	logic [31:0]                w_data;
	logic [3:0]                 w_strb;
	logic                       next_aw_held;
	logic                       next_w_held;
	logic [7:0]                 next_aw_addr;
	logic [31:0]                next_w_data;
	logic [3:0]                 next_w_strb;
	logic                       next_bvalid;
	logic [1:0]                 next_bresp;
	logic                       next_rvalid;
	logic [1:0]                 next_rresp;
	logic [31:0]                next_rdata;
	roi_state_type              state;
	roi_state_type              next_state;
	logic [7:0]                 timer;
	logic [7:0]                 next_timer;
	logic [`ROI_CNT_W-1:0]      row_count;
	logic [`ROI_CNT_W-1:0]      next_row_count;
	logic [`ROI_CNT_W-1:0]      col_count;
	logic [`ROI_CNT_W-1:0]      next_col_count;
	logic [`ROI_ADDR_W-1:0]     next_col_addr;
	logic [`ROI_ADDR_W-1:0]     next_row_addr_sel;
	logic [`ROI_ADDR_W-1:0]     next_row_addr_prep;
	logic [2:0]                 sync_x_pipe;
	logic [2:0]                 sync_y_pipe;
	logic                       sync_x_rise;
	logic                       sync_y_rise;
	logic [`ROI_ADDR_W-1:0]     row_origin;
	logic [`ROI_ADDR_W-1:0]     col_origin;
	roi_stream_if #(.WIDTH(2*`ROI_PIX_W)) to_fifo ();
	roi_stream_if #(.WIDTH(2*`ROI_PIX_W)) to_stage ();
	// ==========================================================================
	// Bus slave
	assign s_axi_awready = ce && !aw_held && !s_axi_bvalid;
	assign s_axi_wready  = ce && !w_held && !s_axi_bvalid;
	assign s_axi_arready = ce && !s_axi_rvalid;
	always_comb begin
		next_aw_held    = aw_held;
		next_w_held     = w_held;
		next_aw_addr    = aw_addr;
		next_w_data     = w_data;
		next_w_strb     = w_strb;
		next_bvalid     = s_axi_bvalid && !s_axi_bready;
		next_bresp      = s_axi_bresp;
		next_rvalid     = s_axi_rvalid && !s_axi_rready;
		next_rresp      = s_axi_rresp;
		next_rdata      = s_axi_rdata;
		next_ctrl       = ctrl;
		next_row_start  = row_start;
		next_col_start  = col_start;
		next_ref_code   = ref_code;
		next_win_width  = win_width;
		next_win_height = win_height;
		if (s_axi_awvalid && s_axi_awready) begin
			next_aw_held = 1'b1;
			next_aw_addr = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			next_w_held = 1'b1;
			next_w_data = s_axi_wdata;
			next_w_strb = s_axi_wstrb;
		end
		if (aw_held && w_held && !s_axi_bvalid) begin
			next_aw_held = 1'b0;
			next_w_held  = 1'b0;
			next_bvalid  = 1'b1;
			next_bresp   = 2'h0;
			case (decode(aw_addr))
				ROI_SEL_CTRL:   next_ctrl       = 2'(merge({30'h0, ctrl}, w_data, w_strb));
				ROI_SEL_ROW:    next_row_start  = 10'(merge({22'h0, row_start}, w_data, w_strb));
				ROI_SEL_COL:    next_col_start  = 10'(merge({22'h0, col_start}, w_data, w_strb));
				ROI_SEL_REF:    next_ref_code   = 7'(merge({25'h0, ref_code}, w_data, w_strb));
				ROI_SEL_WIDTH:  next_win_width  = 12'(merge({20'h0, win_width}, w_data, w_strb));
				ROI_SEL_HEIGHT: next_win_height = 12'(merge({20'h0, win_height}, w_data, w_strb));
				ROI_SEL_STATUS: next_bresp      = 2'h0;
				default:        next_bresp      = 2'h2;
			endcase
		end
		if (s_axi_arvalid && s_axi_arready) begin
			next_rvalid = 1'b1;
			next_rresp  = (decode(s_axi_araddr) == ROI_SEL_NONE) ? 2'h2 : 2'h0;
			case (decode(s_axi_araddr))
				ROI_SEL_CTRL:   next_rdata = {30'h0, ctrl};
				ROI_SEL_ROW:    next_rdata = {22'h0, row_start};
				ROI_SEL_COL:    next_rdata = {22'h0, col_start};
				ROI_SEL_REF:    next_rdata = {25'h0, ref_code};
				ROI_SEL_WIDTH:  next_rdata = {20'h0, win_width};
				ROI_SEL_HEIGHT: next_rdata = {20'h0, win_height};
				ROI_SEL_STATUS: next_rdata = {4'h0, row_count, 9'h0, state, 3'h0, frame_busy};
				default:        next_rdata = 32'h0;
			endcase
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held      <= 1'b0;
			w_held       <= 1'b0;
			aw_addr      <= 8'h00;
			w_data       <= 32'h0;
			w_strb       <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= 2'h0;
			s_axi_rvalid <= 1'b0;
			s_axi_rresp  <= 2'h0;
			s_axi_rdata  <= 32'h0;
			ctrl         <= `ROI_CTRL_RST;
			row_start    <= `ROI_START_RST;
			col_start    <= `ROI_START_RST;
			ref_code     <= `ROI_REF_RST;
			win_width    <= `ROI_ARRAY_RST;
			win_height   <= `ROI_ARRAY_RST;
		end else if (ce) begin
			aw_held      <= next_aw_held;
			w_held       <= next_w_held;
			aw_addr      <= next_aw_addr;
			w_data       <= next_w_data;
			w_strb       <= next_w_strb;
			s_axi_bvalid <= next_bvalid;
			s_axi_bresp  <= next_bresp;
			s_axi_rvalid <= next_rvalid;
			s_axi_rresp  <= next_rresp;
			s_axi_rdata  <= next_rdata;
			ctrl         <= next_ctrl;
			row_start    <= next_row_start;
			col_start    <= next_col_start;
			ref_code     <= next_ref_code;
			win_width    <= next_win_width;
			win_height   <= next_win_height;
		end
	end
	// ==========================================================================
	// Sync pulse synchronisers; edges are taken from the second and third stages only.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sync_x_pipe <= 3'h0;
			sync_y_pipe <= 3'h0;
		end else if (ce) begin
			sync_x_pipe <= {sync_x_pipe[1:0], sync_x_pin};
			sync_y_pipe <= {sync_y_pipe[1:0], sync_y_pin};
		end
	end
	assign sync_x_rise = sync_x_pipe[1] && !sync_x_pipe[2];
	assign sync_y_rise = sync_y_pipe[1] && !sync_y_pipe[2];
	assign row_origin  = {row_start, 1'b0};
	assign col_origin  = {col_start, 1'b0};
	// ==========================================================================
	// Frame sequencer
	assign frame_busy     = (state != ROI_IDLE);
	assign to_fifo.valid  = ce && (state == ROI_PIX);
	assign to_fifo.data   = {col_bus_odd, col_bus_even};
	always_comb begin
		next_state         = state;
		next_timer         = timer;
		next_row_count     = row_count;
		next_col_count     = col_count;
		next_col_addr      = col_addr;
		next_row_addr_sel  = row_addr_sel;
		next_row_addr_prep = row_addr_prep;
		case (state)
			ROI_IDLE: begin
				if (sync_y_rise && ctrl[`ROI_CTRL_ENABLE]) begin
					next_state     = ROI_FOT;
					next_timer     = FOT_LAST;
					next_row_count = '0;
				end
			end
			ROI_FOT: begin
				if (timer == 8'h00) begin
					next_state = ROI_ROT;
					next_timer = ROT_LAST;
				end else begin
					next_timer = timer - 8'h01;
				end
			end
			ROI_ROT: begin
				if (timer == 8'h00) begin
					next_state     = ROI_PIX;
					next_col_count = '0;
					next_col_addr  = col_origin;
				end else begin
					next_timer = timer - 8'h01;
				end
			end
			ROI_PIX: begin
				if (to_fifo.ready) begin
					next_col_count = col_count + 12'h002;
					next_col_addr  = col_addr + 11'h002;
					if (col_count + 12'h002 >= win_width) begin
						if (row_count + 12'h001 >= win_height) begin
							next_state = ROI_IDLE;
						end else begin
							next_state         = ROI_ROT;
							next_timer         = ROT_LAST;
							next_row_count     = row_count + 12'h001;
							next_row_addr_sel  = row_addr_sel + 11'h001;
							next_row_addr_prep = row_addr_prep + 11'h001;
						end
					end
				end
			end
			default: next_state = ROI_IDLE;
		endcase
		// A sync pulse wins over the sequencer's own stepping in the same cycle.
		if (sync_x_rise) begin
			next_col_addr = col_origin;
		end
		if (sync_y_rise) begin
			next_row_addr_sel  = row_origin;
			next_row_addr_prep = row_origin + 11'h001;
		end
	end
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state         <= ROI_IDLE;
			timer         <= 8'h00;
			row_count     <= '0;
			col_count     <= '0;
			col_addr      <= '0;
			row_addr_sel  <= '0;
			row_addr_prep <= 11'h001;
		end else if (ce) begin
			state         <= next_state;
			timer         <= next_timer;
			row_count     <= next_row_count;
			col_count     <= next_col_count;
			col_addr      <= next_col_addr;
			row_addr_sel  <= next_row_addr_sel;
			row_addr_prep <= next_row_addr_prep;
		end
	end
	// ==========================================================================
	// Pixel buffering and output stages
	// The FIFO absorbs the rate gap in single-output mode by stalling the column walk.
	roi_fifo #(
		.WIDTH (2*`ROI_PIX_W),
		.DEPTH (`ROI_FIFO_DEPTH)
	) roi_fifo_inst (
		.aclk    (aclk),
		.aresetn (aresetn),
		.ce      (ce),
		.in_s    (to_fifo.sink),
		.out_s   (to_stage.source)
	);
	roi_out_stage roi_out_stage_inst (
		.aclk                     (aclk),
		.aresetn                  (aresetn),
		.ce                       (ce),
		.dual                     (ctrl[`ROI_CTRL_DUAL]),
		.ref_code                 (ref_code),
		.pairs                    (to_stage.sink),
		.pixel_signal_output_a    (pixel_signal_output_a),
		.pixel_signal_output_b    (pixel_signal_output_b),
		.pixel_strobe             (pixel_strobe),
		.reference_level_output_a (reference_level_output_a),
		.reference_level_output_b (reference_level_output_b)
	);
endmodule : roi_readout
`default_nettype wire

// ==== roi_readout_chk.sv ====
// Concurrent checks on the readout sequencer ports.
`timescale 1ns/1ps
`default_nettype none
`include "roi_defs.svh"
// ==========================================
// Port checker
module roi_readout_chk (
	input wire logic                    aclk,
	input wire logic                    aresetn,
	input wire logic                    s_axi_awvalid,
	input wire logic                    s_axi_awready,
	input wire logic                    s_axi_wvalid,
	input wire logic                    s_axi_wready,
	input wire logic                    s_axi_bvalid,
	input wire logic                    s_axi_bready,
	input wire logic [1:0]              s_axi_bresp,
	input wire logic                    s_axi_arvalid,
	input wire logic                    s_axi_arready,
	input wire logic                    s_axi_rvalid,
	input wire logic                    s_axi_rready,
	input wire logic [31:0]             s_axi_rdata,
	input wire logic [`ROI_ADDR_W-1:0]  col_addr,
	input wire logic [`ROI_ADDR_W-1:0]  row_addr_sel,
	input wire logic [`ROI_ADDR_W-1:0]  row_addr_prep,
	input wire logic                    frame_busy,
	input wire logic                    pixel_strobe,
	input wire logic [`ROI_REF_W-1:0]   reference_level_output_a,
	input wire logic [`ROI_REF_W-1:0]   reference_level_output_b
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	a_ref_pair: assert property (reference_level_output_a == reference_level_output_b)
		else $error("reference outputs differ");
	a_row_pair: assert property (row_addr_prep == row_addr_sel + 11'h001)
		else $error("second row register not one ahead");
	a_col_even: assert property (col_addr[0] == 1'b0)
		else $error("odd column address");
	a_row_even: assert property ($rose(frame_busy) |-> row_addr_sel[0] == 1'b0)
		else $error("frame starts on odd row");
	a_fot_quiet: assert property ($rose(frame_busy) |-> !pixel_strobe [*8])
		else $error("pixel during frame overhead");
	a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
		else $error("write response late");
	a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read response late");
	a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped");
	a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped");
	c_strobe: cover property (pixel_strobe);
	c_frame: cover property ($rose(frame_busy));
	c_bwait: cover property (s_axi_bvalid && !s_axi_bready);
endmodule : roi_readout_chk
bind roi_readout roi_readout_chk roi_readout_chk_inst (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
	.s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready,
	.s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .col_addr, .row_addr_sel, .row_addr_prep, .frame_busy,
	.pixel_strobe, .reference_level_output_a, .reference_level_output_b);
`default_nettype wire

// ==== roi_ctrl_model.sv ====
// Camera controller model: sync pulses and column bus contents.
`timescale 1ns/1ps
`default_nettype none
`include "roi_defs.svh"
// ==========================================
// Controller model
module roi_ctrl_model (
	input  wire logic                   aclk,
	input  wire logic [`ROI_ADDR_W-1:0] col_addr,
	output var logic                    sync_x_pin = 1'b0,
	output var logic                    sync_y_pin = 1'b0,
	output logic [`ROI_PIX_W-1:0]       col_bus_even,
	output logic [`ROI_PIX_W-1:0]       col_bus_odd
);
	// Each sample carries its own column number, so order errors show up.
	assign col_bus_even = col_addr[9:0];
	assign col_bus_odd = col_addr[9:0] + 10'h001;
	// The pulse spans four edges so the three-stage synchroniser cannot miss it.
	task automatic pulse(input logic y);
		@(posedge aclk);
		if (y) sync_y_pin <= 1'b1;
		else sync_x_pin <= 1'b1;
		repeat (4) @(posedge aclk);
		sync_y_pin <= 1'b0;
		sync_x_pin <= 1'b0;
	endtask : pulse
endmodule : roi_ctrl_model
`default_nettype wire

// ==== roi_readout_test.sv ====
// Self-checking testbench for the readout sequencer.
`timescale 1ns/1ps
`default_nettype none
`include "roi_defs.svh"
// ==========================================
// Testbench
module roi_readout_test;
	logic aclk = 1'b0, aresetn = 1'b0, ce = 1'b1, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
	logic s_axi_rvalid, sync_x_pin, sync_y_pin, frame_busy, pixel_strobe;
	logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic [2:0] s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
	logic [3:0] s_axi_wstrb = 4'hF;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [9:0] col_bus_even, col_bus_odd, pixel_signal_output_a, pixel_signal_output_b;
	logic [10:0] col_addr, row_addr_sel, row_addr_prep;
	logic [6:0] reference_level_output_a, reference_level_output_b;
	logic [9:0] qa[$], qb[$];
	int fails = 0, n_checks = 0;
	always #50 aclk = ~aclk;
	roi_readout roi_readout_inst (.*);
	roi_ctrl_model roi_ctrl_model_inst (.aclk, .col_addr, .sync_x_pin, .sync_y_pin, .col_bus_even, .col_bus_odd);
	task automatic complete_run;
		if (fails == 0 && n_checks > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask : complete_run
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
		n_checks++;
		if (seen !== exp) begin
			fails++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk
	task automatic limit(input int n, input int top);
		if (n >= top) begin
			fails++;
			complete_run;
		end
	endtask : limit
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		int n;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		for (n = 0; n < 60; n++) begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
			if (s_axi_bready && s_axi_bvalid) break;
			if (n == 2) s_axi_bready <= 1'b1;
		end
		s_axi_bready <= 1'b0;
		limit(n, 60);
		chk(s_axi_bresp, er, "bresp");
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
		int n;
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		for (n = 0; n < 60; n++) begin
			@(posedge aclk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
			if (s_axi_rready && s_axi_rvalid) break;
			if (n == 2) s_axi_rready <= 1'b1;
		end
		s_axi_rready <= 1'b0;
		limit(n, 60);
		chk(s_axi_rdata, exp, "rdata");
		chk(s_axi_rresp, er, "rresp");
	endtask : rd
	task automatic t_regs;
		rd(`ROI_REG_REF_LEVEL, 32'h0000007F, 2'h0);
		rd(`ROI_REG_WIN_HEIGHT, 32'h00000800, 2'h0);
		rd(8'h1C, 32'h0, 2'h2);
		wr(`ROI_REG_STATUS, 32'hFFFFFFFF, 2'h0);
		rd(`ROI_REG_STATUS, 32'h0, 2'h0);
		wr(`ROI_REG_COL_START, 32'hFFFFFFFF, 2'h0);
		rd(`ROI_REG_COL_START, 32'h000003FF, 2'h0);
		wr(`ROI_REG_REF_LEVEL, 32'h00000015, 2'h0);
		repeat (2) @(posedge aclk);
		chk(reference_level_output_b, 32'h15, "ref b");
		wr(`ROI_REG_REF_LEVEL, 32'h0000007F, 2'h0);
	endtask : t_regs
	task automatic frame(input logic dual, input logic [31:0] r, input logic [31:0] c, input int w, input int h);
		int n, len, k, e;
		k = dual ? w * h / 2 : w * h;
		e = `ROI_FOT_CYC + h * (`ROI_ROT_CYC + w / 2);
		len = 0;
		qa.delete();
		qb.delete();
		wr(`ROI_REG_ROW_START, r, 2'h0);
		wr(`ROI_REG_COL_START, c, 2'h0);
		wr(`ROI_REG_WIN_WIDTH, w, 2'h0);
		wr(`ROI_REG_WIN_HEIGHT, h, 2'h0);
		wr(`ROI_REG_CTRL, {dual, 1'b1}, 2'h0);
		roi_ctrl_model_inst.pulse(1'b0);
		repeat (3) @(posedge aclk);
		chk(col_addr, 2 * c, "col preset");
		fork
			roi_ctrl_model_inst.pulse(1'b1);
		join_none
		for (n = 0; n < 400 && !(len > 0 && !frame_busy && qa.size() >= k); n++) begin
			@(posedge aclk);
			if (pixel_strobe) qa.push_back(pixel_signal_output_a);
			if (pixel_strobe) qb.push_back(pixel_signal_output_b);
			if (frame_busy) len++;
			if (len == 1 && frame_busy) chk(row_addr_sel, 2 * r, "row start");
		end
		limit(n, 400);
		chk(len >= e && len <= e + 4, 1'b1, "frame length");
		chk(qa.size(), k, "sample count");
		for (n = 0; n < k && n < qa.size(); n++) begin
			chk(qa[n], 2 * c + (dual ? 2 : 1) * (n % (k / h)), "out a");
			chk(qb[n], dual ? 2 * c + 2 * (n % (k / h)) + 1 : 0, "out b");
		end
	endtask : frame
	initial begin
		repeat (10) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (3) @(posedge aclk);
		t_regs;
		frame(1'b1, 1, 1, 4, 2);
		frame(1'b0, 3, 5, 6, 1);
		complete_run;
	end
endmodule : roi_readout_test
`default_nettype wire
